// ### dhc_cfg.svh
/*
  Constants of the DMA channel handshake and cascade block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 32-bit classic Wishbone register bus and a 40 MHz clock.
*/
`ifndef DHC_CFG_SVH
`define DHC_CFG_SVH

// register byte offsets
`define DHC_REG_CTRL      8'h00
`define DHC_REG_STATUS    8'h04
`define DHC_REG_BLEN      8'h08
`define DHC_REG_STATE     8'h0C

// control register fields
`define DHC_CTRL_EN_LSB    0
`define DHC_CTRL_MASK_LSB  4
`define DHC_CTRL_DOUBLE    8
`define DHC_CTRL_DRIVE     9
`define DHC_CTRL_AF_IRQ    10
`define DHC_CTRL_ODD_PAR   11
`define DHC_CTRL_RESET     16'h00F0

// status register fields
`define DHC_ST_PAR_LSB     0
`define DHC_ST_ADDR_LSB    4
`define DHC_ST_DONE_LSB    8
`define DHC_ST_TMO_LSB     12

// block length reset value
`define DHC_BLEN_RESET     16'h0001

// timing
`define DHC_CLK_MHZ        40
`define DHC_TIMEOUT_NS     6400
`define DHC_TIMEOUT_CYC    ((`DHC_TIMEOUT_NS * `DHC_CLK_MHZ) / 1000)

`endif

// ### dhc_pkg.sv
/*
  Types of the DMA channel handshake and cascade block.
  Assumes nothing beyond the compile order header, package, module.
*/
`default_nettype none
package dhc_pkg;

  typedef enum logic [2:0] {
    DHC_IDLE,
    DHC_ADDR,
    DHC_DATA,
    DHC_PASS,
    DHC_END
  } dhc_state_t;

endpackage : dhc_pkg
`default_nettype wire

// ### dhc_top.sv
/*
  Pin-level handshake, cascade and fault logic of a four-channel DMA controller,
  with a classic Wishbone slave for its control and status registers.
  Assumes one clock; all pins synchronous to it; the active edge of clk_i plays
  the part of the falling clock edge at which pins are sampled and driven.
*/
// Overview of operation
// - pass grant downstream when lower controller is served
// - interrupt pulse on block end or error
// - parity fault at strobe end stops channel
// - global enable low blocks all requests
// - parity disable skips data parity check, not the parity fault pin
// - timeout disable holds bus timeout in reset
// - addressing faults at strobe end stop channel
// - sampled request starts only enabled unmasked channel
// - request returning high ends current transfer
// - only serviced channel acknowledge goes low
// - acknowledge releases on request high and ready low
// - word indicator high first, low second word
// - drive strobe low exactly while driving data
// - sample strobe low exactly while taking data
// - control inputs registered at the sampling edge
// - handshake outputs updated from the sampling edge
`timescale 1ns/100ps
`default_nettype none
`include "dhc_cfg.svh"

module dhc_top
  import dhc_pkg::*;
#(
  parameter int NUM_CH      = 4,
  parameter int BLEN_W      = 16,
  parameter int TIMEOUT_CYC = `DHC_TIMEOUT_CYC
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // arbiter and cascade
  input  wire logic              bus_grant_n,
  input  wire logic              grant_qualify_in_n,
  input  wire logic              downstream_request_n,
  input  wire logic              controller_global_enable,
  output logic                   bus_request_n,
  output logic                   grant_pass_out_n,
  output logic                   bus_owner_ack_n,
  output logic                   bus_hold_n,
  // bus cycle and faults
  output logic                   addr_strobe_o,
  input  wire logic              bus_ready_n,
  input  wire logic [16:0]       data_i,
  input  wire logic              parity_fault_in_n,
  input  wire logic              memory_protect_fault_n,
  input  wire logic              external_address_fault_n,
  input  wire logic              parity_check_disable_n,
  input  wire logic              bus_timeout_disable_n,
  // peripheral handshake
  input  wire logic [NUM_CH-1:0] channel_request_n,
  output logic      [NUM_CH-1:0] channel_acknowledge_n,
  output logic                   first_word_indicator,
  output logic                   drive_data_strobe_n,
  output logic                   sample_data_strobe_n,
  // events
  output logic                   block_end_pulse_n,
  output logic                   interrupt_pulse_n
);

  if (NUM_CH < 1 || NUM_CH > 4 || BLEN_W < 1 || BLEN_W > 16 || TIMEOUT_CYC < 1)
  begin : g_bad_param
    $error("dhc_top: unsupported parameter values");
  end

  localparam int TMO_W = $clog2(TIMEOUT_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // registered pins

  logic              grant_q;
  logic              qualify_q;
  logic              down_req_q;
  logic              ready_q;
  logic              par_dis_q;
  logic              tmo_dis_q;
  logic              gen_q;
  logic [NUM_CH-1:0] req_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      grant_q    <= 1'b0;
      qualify_q  <= 1'b0;
      down_req_q <= 1'b0;
      ready_q    <= 1'b0;
      par_dis_q  <= 1'b0;
      tmo_dis_q  <= 1'b0;
      gen_q      <= 1'b0;
      req_q      <= '0;
    end
    else
    begin
      // active-high internal copies
      grant_q    <= ~bus_grant_n;
      qualify_q  <= ~grant_qualify_in_n;
      down_req_q <= ~downstream_request_n;
      ready_q    <= ~bus_ready_n;
      par_dis_q  <= ~parity_check_disable_n;
      tmo_dis_q  <= ~bus_timeout_disable_n;
      gen_q      <= controller_global_enable;
      req_q      <= ~channel_request_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers and bus decode

  logic [15:0]       ctrl;
  logic [15:0]       status;
  logic [BLEN_W-1:0] blen;
  dhc_state_t        state;
  logic [1:0]        cur_ch;
  logic              first_word;

  wire        wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the edge where the master sees ack
  wire        wb_wr      = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire        hit_ctrl   = wb_adr_i == `DHC_REG_CTRL;
  wire        hit_status = wb_adr_i == `DHC_REG_STATUS;
  wire        hit_blen   = wb_adr_i == `DHC_REG_BLEN;
  wire        hit_state  = wb_adr_i == `DHC_REG_STATE;
  wire [15:0] wr_mask    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] wr_low     = wb_dat_i[15:0] & wr_mask;
  wire [BLEN_W-1:0] blen_new = BLEN_W'((16'(blen) & ~wr_mask) | wr_low);

  wire [NUM_CH-1:0] ch_en    = ctrl[`DHC_CTRL_EN_LSB +: NUM_CH];
  wire [NUM_CH-1:0] ch_mask  = ctrl[`DHC_CTRL_MASK_LSB +: NUM_CH];
  wire              dbl_mode = ctrl[`DHC_CTRL_DOUBLE];
  wire              drive    = ctrl[`DHC_CTRL_DRIVE];
  wire              af_irq   = ctrl[`DHC_CTRL_AF_IRQ];
  wire              odd_par  = ctrl[`DHC_CTRL_ODD_PAR];

  wire [31:0] state_word = {24'h000000, 1'b0, first_word, cur_ch,
                            1'b0, 3'(state)};
  wire [31:0] rd_data    = hit_ctrl   ? {16'h0000, ctrl} :
                           hit_status ? {16'h0000, status} :
                           hit_blen   ? 32'(blen) :
                           hit_state  ? state_word : 32'h00000000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl     <= `DHC_CTRL_RESET;
      blen     <= BLEN_W'(`DHC_BLEN_RESET);
    end
    else
    begin
      // one wait state; unmapped reads return zero, unmapped writes dropped
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h00000000;
      if (wb_wr && hit_ctrl)
        ctrl <= (ctrl & ~wr_mask) | wr_low;
      if (wb_wr && hit_blen)
        blen <= blen_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel selection

  function automatic logic [1:0] dhc_first_set(input logic [NUM_CH-1:0] v);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (v[i])
        idx = 2'(i);
    return idx;
  endfunction : dhc_first_set

  // a channel with a parity, address or timeout flag stays stopped until software clears those flags
  wire [NUM_CH-1:0] ch_fault;
  wire [NUM_CH-1:0] pend;
  wire [NUM_CH-1:0] cur_onehot = NUM_CH'(1) << cur_ch;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      assign ch_fault[g] = status[`DHC_ST_PAR_LSB + g] | status[`DHC_ST_ADDR_LSB + g]
                           | status[`DHC_ST_TMO_LSB + g];
    end
  endgenerate

  assign pend = req_q & ch_en & ~ch_mask & ~ch_fault & {NUM_CH{gen_q}};

  wire        own_pend  = |pend;
  wire        down_pend = down_req_q & gen_q;
  wire        granted   = grant_q & qualify_q;
  wire [1:0]  pick_ch   = dhc_first_set(pend);

  ////////////////////////////////////////////////////////////////////////////////
  // fault detection

  wire par_bad   = ~par_dis_q & ~drive & ((^data_i) != odd_par);
  wire par_fault = ~parity_fault_in_n | par_bad;
  wire adr_fault = ~memory_protect_fault_n | ~external_address_fault_n;

  logic [TMO_W-1:0] tmo_cnt;
  wire  tmo_hit = tmo_cnt == TMO_W'(TIMEOUT_CYC);

  wire  strobe_end = state == DHC_ADDR;
  wire  set_par    = strobe_end & par_fault;
  wire  set_adr    = strobe_end & adr_fault;
  wire  set_tmo    = state == DHC_DATA & tmo_hit;
  wire  word_step  = state == DHC_DATA & ready_q & req_q[cur_ch] & dbl_mode
                     & first_word;
  wire  release_ack = state == DHC_DATA & ready_q & ~req_q[cur_ch];

  logic [BLEN_W-1:0] remain [NUM_CH];
  wire  last_word = remain[cur_ch] <= BLEN_W'(1);
  wire  set_done  = release_ack & last_word;

  ////////////////////////////////////////////////////////////////////////////////
  // status flags, set wins over software clear

  wire [15:0] clr_bits = (wb_wr && hit_status) ? wr_low : 16'h0000;
  wire [15:0] set_bits = (16'(set_par & ~set_adr) << (`DHC_ST_PAR_LSB + cur_ch))
                       | (16'(set_adr) << (`DHC_ST_ADDR_LSB + cur_ch))
                       | (16'(set_done) << (`DHC_ST_DONE_LSB + cur_ch))
                       | (16'(set_tmo) << (`DHC_ST_TMO_LSB + cur_ch));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status <= 16'h0000;
    else
      status <= (status & ~clr_bits) | set_bits;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // remaining word counters

  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_cnt
      always_ff @(posedge clk_i)
      begin
        // reload takes the value being written, not the stale length
        if (rst_i)
          remain[g] <= BLEN_W'(`DHC_BLEN_RESET);
        else if (wb_wr && hit_blen)
          remain[g] <= blen_new;
        else if (release_ack && cur_ch == 2'(g))
          remain[g] <= last_word ? blen : remain[g] - BLEN_W'(1);
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // bus timeout

  always_ff @(posedge clk_i)
  begin
    if (rst_i || tmo_dis_q || state != DHC_DATA || ready_q)
      tmo_cnt <= '0;
    else if (!tmo_hit)
      tmo_cnt <= tmo_cnt + TMO_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cycle sequencer

  dhc_state_t next_state;

  always_comb
  begin
    next_state = state;
    case (state)
      DHC_IDLE:
        if (granted && own_pend)
          next_state = DHC_ADDR;
        else if (granted && down_pend)
          next_state = DHC_PASS;
      DHC_ADDR:
        next_state = (par_fault || adr_fault) ? DHC_END : DHC_DATA;
      DHC_DATA:
        if (set_tmo || release_ack)
          next_state = DHC_END;
      DHC_PASS:
        if (!granted || !down_pend)
          next_state = DHC_IDLE;
      DHC_END:
        next_state = DHC_IDLE;
      default:
        next_state = DHC_IDLE;
    endcase
  end

  wire own_cycle = next_state == DHC_ADDR || next_state == DHC_DATA;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state      <= DHC_IDLE;
      cur_ch     <= 2'h0;
      first_word <= 1'b1;
    end
    else
    begin
      state <= next_state;
      if (state == DHC_IDLE)
        cur_ch <= pick_ch;
      if (state != DHC_DATA)
        first_word <= 1'b1;
      else if (word_step)
        first_word <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin outputs

  wire in_data = next_state == DHC_DATA;
  wire irq_evt = set_done | set_par | set_tmo | (set_adr & af_irq);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_request_n         <= 1'b1;
      grant_pass_out_n      <= 1'b1;
      bus_owner_ack_n       <= 1'b1;
      bus_hold_n            <= 1'b1;
      addr_strobe_o         <= 1'b0;
      channel_acknowledge_n <= '1;
      first_word_indicator  <= 1'b1;
      drive_data_strobe_n   <= 1'b1;
      sample_data_strobe_n  <= 1'b1;
      block_end_pulse_n     <= 1'b1;
      interrupt_pulse_n     <= 1'b1;
    end
    else
    begin
      // all handshake pins change only at the sampling edge
      bus_request_n         <= ~(own_pend | down_pend | own_cycle);
      grant_pass_out_n      <= ~(next_state == DHC_PASS);
      bus_owner_ack_n       <= ~own_cycle;
      bus_hold_n            <= ~(own_cycle & dbl_mode & first_word & ~word_step);
      addr_strobe_o         <= next_state == DHC_ADDR;
      channel_acknowledge_n <= ~(cur_onehot & {NUM_CH{in_data}});
      first_word_indicator  <= ~(in_data & ~(first_word & ~word_step));
      drive_data_strobe_n   <= ~(in_data & drive);
      sample_data_strobe_n  <= ~(in_data & ~drive);
      block_end_pulse_n     <= ~set_done;
      interrupt_pulse_n     <= ~irq_evt;
    end
  end

endmodule : dhc_top
`default_nettype wire

// ### dhc_top_monitor.sv
/* pin checker for dhc_top.
   assumes one clock, rst_i synchronous active high. */
`timescale 1ns/100ps
`default_nettype none
module dhc_top_monitor #(
  parameter int NUM_CH = 4
)
(
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // arbiter side
  input wire logic              bus_grant_n,
  input wire logic              grant_qualify_in_n,
  input wire logic              controller_global_enable,
  input wire logic              bus_request_n,
  input wire logic              grant_pass_out_n,
  input wire logic              bus_owner_ack_n,
  input wire logic              bus_hold_n,
  // bus cycle and handshake
  input wire logic              addr_strobe_o,
  input wire logic              bus_ready_n,
  input wire logic [NUM_CH-1:0] channel_acknowledge_n,
  input wire logic              first_word_indicator,
  input wire logic              drive_data_strobe_n,
  input wire logic              sample_data_strobe_n,
  input wire logic              block_end_pulse_n,
  input wire logic              interrupt_pulse_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_own; $fell(bus_owner_ack_n) ##0 addr_strobe_o; endsequence
  sequence s_off; !controller_global_enable [*3]; endsequence
  ack_onehot_a: assert property ($onehot0(~channel_acknowledge_n))
    else $error("two acknowledges low");
  owner_grant_a: assert property ($fell(bus_owner_ack_n) |->
    !$past(bus_grant_n, 2) && !$past(grant_qualify_in_n, 2)) else $error("own cycle without grant");
  addr_once_a: assert property (s_own |=> !addr_strobe_o)
    else $error("address phase too long");
  pass_excl_a: assert property (!grant_pass_out_n |-> bus_owner_ack_n && &channel_acknowledge_n)
    else $error("grant passed while owning bus");
  drive_win_a: assert property (!drive_data_strobe_n |-> !(&channel_acknowledge_n) && sample_data_strobe_n)
    else $error("drive strobe outside transfer");
  sample_win_a: assert property (!sample_data_strobe_n |-> !(&channel_acknowledge_n))
    else $error("sample strobe outside transfer");
  ack_release_a: assert property ($rose(&channel_acknowledge_n) |-> !$past(bus_ready_n, 2))
    else $error("acknowledge released without ready");
  gate_off_a: assert property (s_off |=> bus_request_n || !bus_owner_ack_n || !(&channel_acknowledge_n))
    else $error("bus request while disabled");
  done_irq_a: assert property ($fell(block_end_pulse_n) |-> !interrupt_pulse_n ##1 block_end_pulse_n)
    else $error("block end without interrupt");
  irq_pulse_a: assert property (!interrupt_pulse_n |=> interrupt_pulse_n)
    else $error("interrupt pulse too long");
  hold_first_a: assert property (!bus_hold_n |-> !bus_owner_ack_n && first_word_indicator)
    else $error("bus hold outside first word");
endmodule : dhc_top_monitor
bind dhc_top dhc_top_monitor #(.NUM_CH(NUM_CH)) u_mon (.clk_i, .rst_i, .bus_grant_n,
  .grant_qualify_in_n, .controller_global_enable, .bus_request_n, .grant_pass_out_n,
  .bus_owner_ack_n, .bus_hold_n, .addr_strobe_o, .bus_ready_n, .channel_acknowledge_n,
  .first_word_indicator, .drive_data_strobe_n, .sample_data_strobe_n, .block_end_pulse_n,
  .interrupt_pulse_n);
`default_nettype wire

// ### dhc_far_model.sv
/* arbiter, target and peripherals beside dhc_top.
   assumes the bench pulses want_i to raise a request, kill_i to drop all. */
`timescale 1ns/100ps
`default_nettype none
module dhc_far_model (
  // clock and control
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  want_i,
  input wire logic        kill_i,
  input wire logic        dbl_i,
  input wire logic [1:0]  slow_i,
  // device pins
  input wire logic        bus_request_n,
  input wire logic        bus_owner_ack_n,
  input wire logic [3:0]  channel_acknowledge_n,
  input wire logic        first_word_indicator,
  output logic            bus_grant_n,
  output logic            bus_ready_n,
  output logic [3:0]      channel_request_n,
  output logic [16:0]     data_i
);
  logic [1:0]  gcnt;
  logic [1:0]  rcnt;
  logic [15:0] d;
  logic        busy;
  assign busy = !(&channel_acknowledge_n);
  // even parity; pattern moves every cycle so stale data never looks valid
  assign data_i = {^d, d};
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      d <= 16'h0000;
    else
      d <= d + 16'h3A5B;
    gcnt <= (bus_request_n || gcnt == 2'h3) ? {2{!bus_request_n}} : gcnt + 2'h1;
    rcnt <= (!busy || rcnt == 2'h3) ? {2{busy}} : rcnt + 2'h1;
    bus_grant_n <= !((!bus_request_n && gcnt >= slow_i) || !bus_owner_ack_n);
    bus_ready_n <= !(busy && rcnt >= slow_i);
    for (int i = 0; i < 4; i++)
      if (rst_i || kill_i || (!channel_acknowledge_n[i] && (!dbl_i || !first_word_indicator)))
        channel_request_n[i] <= 1'b1;
      else if (want_i[i])
        channel_request_n[i] <= 1'b0;
  end
endmodule : dhc_far_model
`default_nettype wire

// ### dhc_top_bench.sv
/* self-checking bench of dhc_top with far side model.
   assumes dhc_top_monitor is bound by its own file. */
`timescale 1ns/100ps
`default_nettype none
`include "dhc_cfg.svh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module dhc_top_bench;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, kill, dbl;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, want, channel_request_n, channel_acknowledge_n;
  logic [31:0] wb_dat_i, wb_dat_o, rnd, r;
  logic        bus_grant_n, grant_qualify_in_n, downstream_request_n, controller_global_enable;
  logic        bus_request_n, grant_pass_out_n, bus_owner_ack_n, bus_hold_n, addr_strobe_o;
  logic        bus_ready_n, parity_fault_in_n, memory_protect_fault_n, external_address_fault_n;
  logic        parity_check_disable_n, bus_timeout_disable_n, first_word_indicator;
  logic        drive_data_strobe_n, sample_data_strobe_n, block_end_pulse_n, interrupt_pulse_n;
  logic [16:0] data_i;
  logic [1:0]  slow;
  logic [10:0] seen;
  int          n_mismatch, checked, cyc;
  dhc_top #(.TIMEOUT_CYC(64)) u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bus_grant_n, .grant_qualify_in_n,
    .downstream_request_n, .controller_global_enable, .bus_request_n, .grant_pass_out_n,
    .bus_owner_ack_n, .bus_hold_n, .addr_strobe_o, .bus_ready_n, .data_i, .parity_fault_in_n,
    .memory_protect_fault_n, .external_address_fault_n, .parity_check_disable_n,
    .bus_timeout_disable_n, .channel_request_n, .channel_acknowledge_n, .first_word_indicator,
    .drive_data_strobe_n, .sample_data_strobe_n, .block_end_pulse_n, .interrupt_pulse_n);
  dhc_far_model u_far (.clk_i, .rst_i, .want_i(want), .kill_i(kill), .dbl_i(dbl), .slow_i(slow),
    .bus_request_n, .bus_owner_ack_n, .channel_acknowledge_n, .first_word_indicator,
    .bus_grant_n, .bus_ready_n, .channel_request_n, .data_i);
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = !clk_i;
  end
  // event recorder: [10:7] ack, smp, drv, second word, pass, request, irq, done
  always @(posedge clk_i)
  begin
    seen <= seen | {~channel_acknowledge_n, !sample_data_strobe_n, !drive_data_strobe_n,
      !first_word_indicator, !grant_pass_out_n, !bus_request_n, !interrupt_pulse_n,
      !block_end_pulse_n};
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // kinds: 0 clean, 1 parity pin, 2 protect, 3 address, 4 odd parity checked, 5 unchecked
  function automatic logic [10:0] exp_seen(input int ch, input logic drv, input logic db, input int k);
    exp_seen = (k == 0 || k == 5) ? {4'h1 << ch, !drv, drv, db, 4'h7} : 11'h006;
  endfunction : exp_seen
  function automatic logic [31:0] exp_st(input int ch, input int k);
    exp_st = (k == 1 || k == 4) ? 32'h1 << ch : (k == 2 || k == 3) ? 32'h10 << ch : 32'h100 << ch;
  endfunction : exp_st
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, wd};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task automatic idle(input int n, input logic [10:0] ex);
    @(negedge clk_i) seen = '0;
    repeat (n) @(posedge clk_i);
    `CHK("silent", ex, seen)
    kill <= 1'b1;
    @(posedge clk_i) kill <= 1'b0;
  endtask : idle
  task automatic xfer(input int ch, input logic drv, input logic db, input int k);
    int n;
    wb(1'b1, `DHC_REG_CTRL, {20'h0, k >= 4, 1'b1, drv, db, 8'h0F});
    @(posedge clk_i);
    {parity_check_disable_n, parity_fault_in_n} <= {k != 5, k != 1};
    {memory_protect_fault_n, external_address_fault_n} <= {k != 2, k != 3};
    {dbl, slow, want} <= {db, rnd[1:0], 4'h1 << ch};
    @(negedge clk_i) seen = '0;
    @(posedge clk_i) want <= 4'h0;
    n = 0;
    while (!(seen[1] || (|seen[10:7] && &channel_acknowledge_n)) && n < 80)
    begin
      @(posedge clk_i);
      n++;
    end
    repeat (3) @(posedge clk_i);
    `CHK("events", exp_seen(ch, drv, db, k) & {8'hFF, !db, !db, 1'b1}, seen & {8'hFF, !db, !db, 1'b1})
    {kill, parity_fault_in_n, memory_protect_fault_n, external_address_fault_n} <= 4'hF;
    wb(1'b0, `DHC_REG_STATUS, 32'h0);
    kill <= 1'b0;
    `CHK("status", exp_st(ch, k), r)
    wb(1'b1, `DHC_REG_STATUS, 32'hFFFF);
    $display("xfer ch %0d kind %0d ended", ch, k);
  endtask : xfer
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 8'h0, 4'hF, 32'h0};
    {grant_qualify_in_n, downstream_request_n, controller_global_enable} = 3'h3;
    {parity_fault_in_n, memory_protect_fault_n, external_address_fault_n} = 3'h7;
    {parity_check_disable_n, bus_timeout_disable_n, kill, dbl, slow, want} = 10'h300;
    {seen, n_mismatch, checked, cyc, rnd} = {11'h0, 96'h0, 32'h4CCE6D45};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `DHC_REG_CTRL, 32'h0);
    `CHK("ctrl reset", {16'h0, `DHC_CTRL_RESET}, r)
    wb(1'b0, `DHC_REG_BLEN, 32'h0);
    `CHK("blen reset", {16'h0, `DHC_BLEN_RESET}, r)
    wb(1'b1, 8'h10, 32'hFFFF);
    wb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, r)
    for (int m = 0; m < 2; m++)
    begin
      wb(1'b1, `DHC_REG_CTRL, m ? 32'h4F : 32'h0B);
      @(posedge clk_i) want <= 4'h4;
      @(posedge clk_i) want <= 4'h0;
      idle(20, 11'h0);
    end
    wb(1'b1, `DHC_REG_CTRL, 32'h0F);
    @(posedge clk_i) {controller_global_enable, downstream_request_n, want} <= 6'h01;
    @(posedge clk_i) want <= 4'h0;
    idle(20, 11'h0);
    @(posedge clk_i) controller_global_enable <= 1'b1;
    idle(20, 11'h00C);
    downstream_request_n <= 1'b1;
    for (int k = 0; k < 6; k++)
      xfer(3, 1'b0, 1'b0, k);
    xfer(0, 1'b0, 1'b1, 0);
    for (int t = 0; t < 14; t++)
    begin
      rnd = lfsr(rnd);
      bus_timeout_disable_n <= rnd[9];
      xfer(rnd[3:2], rnd[4] & (rnd[7:5] % 6 < 4), rnd[8], rnd[7:5] % 6);
    end
    end_of_test();
  end
endmodule : dhc_top_bench
`default_nettype wire
